// *** verilog/drsc_pkg.sv ***
// Shared constants for the reset and sync control block
package drsc_pkg;
   // Reference select pin encodings (two-bit level sense)
   localparam logic [1:0] REFSEL_LOW      = 2'h0;
   localparam logic [1:0] REFSEL_HIGH     = 2'h1;
   localparam logic [1:0] REFSEL_COMMON   = 2'h2;
   // Register file
   localparam int         REG_COUNT       = 237;
   localparam logic [7:0] REG_RESET_VAL   = 8'h00;
   // Converter pipeline depth in clocks
   localparam int         PIPE_DEPTH      = 7;
   // Minimum sync high time in clocks
   localparam int         SYNC_MIN_CLK    = 4;
   // Decimation counter width and reset
   localparam int         DEC_W           = 11;
   localparam logic [10:0] DEC_RESET      = 11'h000;
   localparam logic [15:0] DITHER_SEED_A  = 16'hACE1;
   localparam logic [15:0] DITHER_SEED_B  = 16'h531E;
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RUN   = 2'b01,
      ST_SYNC  = 2'b10
   } drsc_state_t;
endpackage : drsc_pkg

// *** verilog/drsc_sync2.sv ***
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module drsc_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = reset_n ? d : '0;
      q_next    = reset_n ? meta_reg : '0;
   end

   always_ff @(posedge clk) begin
      meta_reg <= meta_next;
      q        <= q_next;
   end
endmodule : drsc_sync2
`default_nettype wire

// *** verilog/drsc_ctrl.sv ***
// Reset, power-down, reference select and sync control of the converter
// What this block does
// - Power-down pin high: converters idle, pipeline data corrupted.
// - Select low, reference high: internal reference, stabiliser enabled.
// - Select high: external reference 0.8V to 1.2V, stabiliser enabled.
// - Select at common-mode: stabiliser off; reference pin picks source.
// - Enabled stabiliser tolerates input clock duty cycle 30% to 70%.
// - 237 byte registers over 8-bit data, address, select, read, write.
// - Port accesses any time, unsynchronised; may upset processing.
// - Master reset clears samples, user data, registers to defaults.
// - Master reset tri-states outputs and asserts both gain-load strobes.
// - Sync acts on third rising clock edge after sync goes high (two-stage synchroniser first).
// - Sync clears samples, loads phase, resets dithers and decimation.
// - Sync leaves processor-loaded configuration unchanged.
// - Samples reach down-converter seven clocks after acquisition.
`timescale 1ns/10ps
`default_nettype none
module drsc_ctrl
   import drsc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Control pins
   input  wire logic        master_reset_pin,
   input  wire logic        power_down_pin,
   input  wire logic [1:0]  reference_select_pin,
   input  wire logic        vref_high_pin,
   input  wire logic        sync_pin,
   // Processor port
   input  wire logic [7:0]  cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_cs_n,
   input  wire logic        cpu_rd_n,
   input  wire logic        cpu_wr_n,
   output logic      [7:0]  cpu_rdata,
   output logic             cpu_rdata_oe_n,
   // Configuration and converter control
   input  wire logic [7:0]  decim_ratio,
   input  wire logic [15:0] phase_offset,
   output logic             adc_power_down,
   output logic             use_internal_ref,
   output logic             duty_cycle_stabiliser,
   output logic             outputs_oe_n,
   output logic             gain_load_a_pulse,
   output logic             gain_load_b_pulse,
   // Sample path
   input  wire logic [11:0] adc_sample,
   output logic      [11:0] ddc_sample,
   output logic             ddc_sample_valid,
   output logic      [15:0] nco_phase,
   output logic      [15:0] dither_a,
   output logic      [15:0] dither_b,
   output logic             decim_strobe
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [5:0] pins_s;
   logic       mr_s;
   logic       pd_s;
   logic [1:0] rsel_s;
   logic       vref_s;
   logic       sync_s;

   drsc_sync2 #(.W(6)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       ({master_reset_pin, power_down_pin, reference_select_pin,
                 vref_high_pin, sync_pin}),
      .q       (pins_s)
   );

   always_comb begin
      mr_s   = pins_s[5];
      pd_s   = pins_s[4];
      rsel_s = pins_s[3:2];
      vref_s = pins_s[1];
      sync_s = pins_s[0];
   end

   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      lfsr_step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_step

   ////////////////////////////////////////////////////////////////////////
   // Register file, written straight from the port strobes
   logic [7:0] regs [REG_COUNT];
   logic       wr_hit;
   logic       rd_hit;

   always_comb begin
      wr_hit = !cpu_cs_n && !cpu_wr_n && (int'(cpu_addr) < REG_COUNT);
      rd_hit = !cpu_cs_n && !cpu_rd_n;
   end

   // registers, unsynchronised access
   // Port strobes sample on the core clock with no resync, so a write may
   // land mid-processing; the host repairs this with a sync afterwards.
   always_ff @(posedge clk) begin
      for (int i = 0; i < REG_COUNT; i++) begin
         if (!reset_n || mr_s) begin
            regs[i] <= REG_RESET_VAL;
         end else if (wr_hit && int'(cpu_addr) == i) begin
            regs[i] <= cpu_wdata;
         end
      end
   end

   logic [7:0] rdata_next;
   logic       rdata_oe_n_next;
   logic [7:0] cpu_rdata_reg;
   logic       cpu_rdata_oe_n_reg;

   always_comb begin
      rdata_next      = 8'h00;
      rdata_oe_n_next = 1'b1;
      if (reset_n && !mr_s && rd_hit) begin
         rdata_oe_n_next = 1'b0;
         if (int'(cpu_addr) < REG_COUNT) begin
            rdata_next = regs[cpu_addr];
         end
      end
   end

   always_ff @(posedge clk) begin
      cpu_rdata_reg      <= rdata_next;
      cpu_rdata_oe_n_reg <= rdata_oe_n_next;
   end

   always_comb begin
      cpu_rdata      = cpu_rdata_reg;
      cpu_rdata_oe_n = cpu_rdata_oe_n_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control state machine
   drsc_state_t state_reg;
   drsc_state_t state_next;
   logic        sync_d_reg;
   logic        sync_d_next;
   logic        sync_rise;

   always_comb begin
      sync_d_next = reset_n ? sync_s : 1'b0;
      // act on first edge after sync rises
      sync_rise   = sync_s && !sync_d_reg;
      state_next  = state_reg;
      if (!reset_n || mr_s) begin
         state_next = ST_RESET;
      end else begin
         unique case (state_reg)
            ST_RESET: state_next = ST_RUN;
            ST_RUN: begin
               if (sync_rise) begin
                  state_next = ST_SYNC;
               end
            end
            ST_SYNC: begin
               if (!sync_s) begin
                  state_next = ST_RUN;
               end
            end
            default: state_next = ST_RESET;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      state_reg  <= state_next;
      sync_d_reg <= sync_d_next;
   end

   logic init_now;
   always_comb begin
      // sync clears and reinitialises datapath state
      init_now = (state_reg != ST_RUN) || sync_rise;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin-level modes and reset outputs
   logic adc_pd_reg;
   logic int_ref_reg;
   logic dcs_reg;
   logic oe_n_reg;
   logic gain_a_reg;
   logic gain_b_reg;
   logic adc_pd_next;
   logic int_ref_next;
   logic dcs_next;
   logic oe_n_next;
   logic gain_next;

   always_comb begin
      adc_pd_next  = pd_s;
      int_ref_next = 1'b1;
      dcs_next     = 1'b1;
      unique case (rsel_s)
         REFSEL_LOW: int_ref_next = 1'b1;
         REFSEL_HIGH: int_ref_next = 1'b0;
         REFSEL_COMMON: begin
            dcs_next     = 1'b0;
            int_ref_next = vref_s;
         end
         // Unused code behaves as select high
         default: int_ref_next = 1'b0;
      endcase
      // tri-state outputs and load gains in reset
      oe_n_next = !reset_n || mr_s;
      gain_next = !reset_n || mr_s;
   end

   always_ff @(posedge clk) begin
      adc_pd_reg  <= reset_n ? adc_pd_next : 1'b0;
      int_ref_reg <= reset_n ? int_ref_next : 1'b1;
      dcs_reg     <= reset_n ? dcs_next : 1'b1;
      oe_n_reg    <= oe_n_next;
      gain_a_reg  <= gain_next;
      gain_b_reg  <= gain_next;
   end

   always_comb begin
      adc_power_down        = adc_pd_reg;
      use_internal_ref      = int_ref_reg;
      duty_cycle_stabiliser = dcs_reg;
      outputs_oe_n          = oe_n_reg;
      gain_load_a_pulse     = gain_a_reg;
      gain_load_b_pulse     = gain_b_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter pipeline
   logic [11:0] pipe_reg  [PIPE_DEPTH];
   logic [11:0] pipe_next [PIPE_DEPTH];
   logic [PIPE_DEPTH-1:0] pv_reg;
   logic [PIPE_DEPTH-1:0] pv_next;

   always_comb begin
      pipe_next[0] = adc_sample;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
         pipe_next[i] = pipe_reg[i-1];
      end
      pv_next = {pv_reg[PIPE_DEPTH-2:0], 1'b1};
      if (pd_s) begin
         pv_next = '0;
      end
      if (init_now) begin
         pv_next = '0;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_next[i] = 12'h000;
         end
      end
   end

   always_ff @(posedge clk) begin
      pipe_reg <= pipe_next;
      pv_reg   <= pv_next;
   end

   always_comb begin
      ddc_sample       = pipe_reg[PIPE_DEPTH-1];
      ddc_sample_valid = pv_reg[PIPE_DEPTH-1];
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator phase, dither and decimation counting
   logic [15:0] phase_reg;
   logic [15:0] phase_next;
   logic [15:0] dith_a_reg;
   logic [15:0] dith_a_next;
   logic [15:0] dith_b_reg;
   logic [15:0] dith_b_next;
   logic [DEC_W-1:0] dec_reg;
   logic [DEC_W-1:0] dec_next;
   logic        dstb_reg;
   logic        dstb_next;
   logic [DEC_W-1:0] dec_last;

   always_comb begin
      // Ratio held outside; zero treated as one to avoid a stuck counter
      dec_last    = (decim_ratio == 8'h00) ? DEC_RESET
                                           : DEC_W'(decim_ratio - 8'h01);
      phase_next  = phase_reg;
      dith_a_next = lfsr_step(dith_a_reg);
      dith_b_next = lfsr_step(dith_b_reg);
      dec_next    = (dec_reg == dec_last) ? DEC_RESET : dec_reg + 11'h001;
      dstb_next   = (dec_reg == dec_last);
      if (init_now) begin
         phase_next  = phase_offset;
         dith_a_next = DITHER_SEED_A;
         dith_b_next = DITHER_SEED_B;
         dec_next    = DEC_RESET;
         dstb_next   = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      phase_reg  <= phase_next;
      dith_a_reg <= dith_a_next;
      dith_b_reg <= dith_b_next;
      dec_reg    <= dec_next;
      dstb_reg   <= dstb_next;
   end

   always_comb begin
      nco_phase    = phase_reg;
      dither_a     = dith_a_reg;
      dither_b     = dith_b_reg;
      decim_strobe = dstb_reg;
   end
endmodule : drsc_ctrl
`default_nettype wire

// *** testbench/drsc_host_model.sv ***
// Host model driving the sync and master reset strobes
`timescale 1ns/10ps
`default_nettype none
module drsc_host_model
   import drsc_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Bench requests
   input  wire logic       sync_req,
   input  wire logic       mr_req,
   input  wire logic [3:0] hold_clks,
   // Strobes to the device
   output var  logic       sync_pin,
   output var  logic       master_reset_pin
);
   int sync_left = 0;
   int mr_left = 0;
   initial begin
      sync_pin = 1'b0;
      master_reset_pin = 1'b0;
   end
   always @(posedge clk) begin
      if (sync_req && sync_left == 0)
         sync_left = SYNC_MIN_CLK + hold_clks;
      else if (sync_left > 0)
         sync_left = sync_left - 1;
      sync_pin <= (sync_left > 0);
   end
   always @(posedge clk) begin
      if (mr_req && mr_left == 0)
         mr_left = 5;
      else if (mr_left > 0)
         mr_left = mr_left - 1;
      master_reset_pin <= (mr_left > 0);
   end
endmodule : drsc_host_model
`default_nettype wire

// *** testbench/drsc_ctrl_asserts.sv ***
// Concurrent checks on the reset and sync control block
`timescale 1ns/10ps
`default_nettype none
module drsc_ctrl_chk
   import drsc_pkg::*;
(
   // Clock, reset and pins
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        master_reset_pin,
   input wire logic        power_down_pin,
   input wire logic [1:0]  reference_select_pin,
   input wire logic        vref_high_pin,
   input wire logic        sync_pin,
   input wire logic        cpu_cs_n,
   input wire logic        cpu_rd_n,
   // Outputs watched, with the inputs they are compared against
   input wire logic        cpu_rdata_oe_n,
   input wire logic [15:0] phase_offset,
   input wire logic        adc_power_down,
   input wire logic        use_internal_ref,
   input wire logic        duty_cycle_stabiliser,
   input wire logic        outputs_oe_n,
   input wire logic        gain_load_a_pulse,
   input wire logic        gain_load_b_pulse,
   input wire logic [11:0] adc_sample,
   input wire logic [11:0] ddc_sample,
   input wire logic        ddc_sample_valid,
   input wire logic [15:0] nco_phase,
   input wire logic [15:0] dither_a,
   input wire logic [15:0] dither_b
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Pins pass synchronisers, so judge only settled levels
   logic [3:0] mr_hist_reg;
   logic       quiet;
   always_ff @(posedge clk) begin
      mr_hist_reg <= {mr_hist_reg[2:0], master_reset_pin};
   end
   assign quiet = (mr_hist_reg == 4'h0) && !master_reset_pin;
   sequence s_sel_steady;
      (quiet && $stable({reference_select_pin, vref_high_pin}))[*5];
   endsequence
   sequence s_sync_rise;
      !sync_pin ##1 sync_pin[*4];
   endsequence
   sequence s_mr_held;
      master_reset_pin[*3];
   endsequence
   a_pd_level: assert property (
      (quiet && $stable(power_down_pin))[*4] |->
      adc_power_down == power_down_pin) else $error("power-down level");
   a_ref_source: assert property (
      s_sel_steady ##0 (reference_select_pin != REFSEL_LOW || vref_high_pin)
      |-> use_internal_ref == (reference_select_pin == REFSEL_LOW ||
      (reference_select_pin == REFSEL_COMMON && vref_high_pin)))
      else $error("reference source");
   a_dcs_select: assert property (
      s_sel_steady |-> duty_cycle_stabiliser ==
      (reference_select_pin != REFSEL_COMMON)) else $error("stabiliser");
   a_mr_tristate: assert property (
      s_mr_held |=> outputs_oe_n && gain_load_a_pulse && gain_load_b_pulse)
      else $error("master reset outputs");
   a_sync_reinit: assert property (
      s_sync_rise |=> nco_phase == phase_offset && !ddc_sample_valid &&
      dither_a == DITHER_SEED_A && dither_b == DITHER_SEED_B)
      else $error("sync reinit");
   a_pipe_delay: assert property (
      ddc_sample_valid && !adc_power_down && $past(adc_power_down, 8) == 1'b0
      |-> ddc_sample == $past(adc_sample, 7)) else $error("pipe delay");
   a_valid_refill: assert property (
      $fell(ddc_sample_valid) |=> !ddc_sample_valid[*6])
      else $error("valid too early");
   a_read_answer: assert property (
      (!cpu_cs_n && !cpu_rd_n)[*2] |-> !cpu_rdata_oe_n)
      else $error("read not driven");
endmodule : drsc_ctrl_chk
bind drsc_ctrl drsc_ctrl_chk u_chk (.clk, .reset_n, .master_reset_pin,
   .power_down_pin, .reference_select_pin, .vref_high_pin, .sync_pin,
   .cpu_cs_n, .cpu_rd_n, .cpu_rdata_oe_n, .phase_offset, .adc_power_down,
   .use_internal_ref, .duty_cycle_stabiliser, .outputs_oe_n,
   .gain_load_a_pulse, .gain_load_b_pulse, .adc_sample, .ddc_sample,
   .ddc_sample_valid, .nco_phase, .dither_a, .dither_b);
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the reset and sync control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; \
   if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb import drsc_pkg::*;;
   logic        clk = 1'b0, reset_n = 1'b0, power_down_pin = 1'b0;
   logic        vref_high_pin = 1'b1, cpu_cs_n = 1'b1, cpu_rd_n = 1'b1;
   logic        cpu_wr_n = 1'b1, sync_req = 1'b0, mr_req = 1'b0;
   logic [1:0]  reference_select_pin = REFSEL_LOW;
   logic [3:0]  hold_clks = 4'h0;
   logic [7:0]  cpu_addr = 8'h00, cpu_wdata = 8'h00, decim_ratio = 8'h08;
   logic [7:0]  cpu_rdata;
   logic [11:0] adc_sample = 12'h000, ddc_sample;
   logic [15:0] phase_offset = 16'h1234, nco_phase, dither_a, dither_b;
   logic        cpu_rdata_oe_n, adc_power_down, use_internal_ref;
   logic        duty_cycle_stabiliser, outputs_oe_n, gain_load_a_pulse;
   logic        gain_load_b_pulse, ddc_sample_valid, decim_strobe;
   logic        sync_pin, master_reset_pin;
   int          mismatches = 0, checks_done = 0, cycles = 0;
   drsc_ctrl uut (.clk, .reset_n, .master_reset_pin, .power_down_pin,
      .reference_select_pin, .vref_high_pin, .sync_pin, .cpu_addr,
      .cpu_wdata, .cpu_cs_n, .cpu_rd_n, .cpu_wr_n, .cpu_rdata,
      .cpu_rdata_oe_n, .decim_ratio, .phase_offset, .adc_power_down,
      .use_internal_ref, .duty_cycle_stabiliser, .outputs_oe_n,
      .gain_load_a_pulse, .gain_load_b_pulse, .adc_sample, .ddc_sample,
      .ddc_sample_valid, .nco_phase, .dither_a, .dither_b, .decim_strobe);
   drsc_host_model host (.clk, .sync_req, .mr_req, .hold_clks, .sync_pin,
      .master_reset_pin);
   always #2.5 clk = ~clk;
   // Ramp makes every sample distinct
   always @(negedge clk) adc_sample <= adc_sample + 12'h001;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic bus(logic wr, logic [7:0] a, d, output logic [7:0] q);
      @(negedge clk);
      {cpu_addr, cpu_wdata} = {a, d};
      {cpu_cs_n, cpu_rd_n, cpu_wr_n} = {1'b0, wr, !wr};
      cyc(2);
      q = cpu_rdata;
      if (!wr) `CHK("read drive", 1'b0, cpu_rdata_oe_n)
      {cpu_cs_n, cpu_rd_n, cpu_wr_n} = 3'h7;
   endtask : bus
   task automatic t_regs();
      logic [7:0] q;
      bus(1'b0, 8'h20, 8'h00, q);
      `CHK("reg default", REG_RESET_VAL, q)
      bus(1'b1, 8'h00, 8'h3C, q);
      bus(1'b1, 8'hEC, 8'hC3, q);
      bus(1'b1, 8'hED, 8'hFF, q);
      bus(1'b0, 8'h00, 8'h00, q);
      `CHK("reg first", 8'h3C, q)
      bus(1'b0, 8'hEC, 8'h00, q);
      `CHK("reg last", 8'hC3, q)
      bus(1'b0, 8'hED, 8'h00, q);
      `CHK("reg beyond", 8'h00, q)
      $display("Test regs done");
   endtask : t_regs
   task automatic t_refsel();
      logic [4:0] tbl [6] = '{5'h07, 5'h0D, 5'h09, 5'h16, 5'h10, 5'h1D};
      foreach (tbl[i]) begin
         {reference_select_pin, vref_high_pin} = tbl[i][4:2];
         cyc(6);
         `CHK("internal ref", tbl[i][1], use_internal_ref)
         `CHK("stabiliser", tbl[i][0], duty_cycle_stabiliser)
      end
      {reference_select_pin, vref_high_pin} = 3'h1;
      $display("Test refsel done");
   endtask : t_refsel
   task automatic t_pd();
      power_down_pin = 1'b1;
      cyc(5);
      `CHK("power down", 1'b1, adc_power_down)
      power_down_pin = 1'b0;
      cyc(5);
      `CHK("power up", 1'b0, adc_power_down)
      $display("Test pd done");
   endtask : t_pd
   task automatic t_pipe();
      for (int n = 0; n < 40 && ddc_sample_valid !== 1'b1; n++) cyc(1);
      // Ramp not yet stepped at this edge, so six back means seven clocks
      repeat (8) begin
         `CHK("sample", adc_sample - 12'h006, ddc_sample)
         cyc(1);
      end
      $display("Test pipe done");
   endtask : t_pipe
   task automatic t_sync(logic [3:0] hold);
      logic [7:0] q;
      int n;
      bus(1'b1, 8'h10, 8'h5A, q);
      phase_offset = phase_offset + 16'h1111;
      hold_clks = hold;
      sync_req = 1'b1;
      cyc(1);
      sync_req = 1'b0;
      for (n = 0; n < 6 && nco_phase !== phase_offset; n++) cyc(1);
      `CHK("sync delay", 1'b1, n < 5)
      `CHK("dither a", DITHER_SEED_A, dither_a)
      `CHK("dither b", DITHER_SEED_B, dither_b)
      `CHK("pipe cleared", 1'b0, ddc_sample_valid)
      for (n = 0; n < 40 && decim_strobe !== 1'b1; n++) cyc(1);
      `CHK("decim restart", 1'b1, decim_strobe)
      cyc(1);
      for (n = 1; n < 40 && decim_strobe !== 1'b1; n++) cyc(1);
      `CHK("decim period", int'(decim_ratio), n)
      bus(1'b0, 8'h10, 8'h00, q);
      `CHK("config kept", 8'h5A, q)
      $display("Test sync done");
   endtask : t_sync
   task automatic t_mr();
      logic [7:0] q;
      logic [2:0] outs;
      bus(1'b1, 8'h10, 8'hA5, q);
      mr_req = 1'b1;
      cyc(1);
      mr_req = 1'b0;
      cyc(4);
      outs = {outputs_oe_n, gain_load_a_pulse, gain_load_b_pulse};
      `CHK("tristate", 3'h7, outs)
      cyc(8);
      bus(1'b0, 8'h10, 8'h00, q);
      `CHK("reg cleared", REG_RESET_VAL, q)
      $display("Test mr done");
   endtask : t_mr
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(6);
      `CHK("reset tristate", 1'b1, outputs_oe_n)
      reset_n = 1'b1;
      cyc(4);
      `CHK("outputs on", 1'b0, outputs_oe_n)
      `CHK("gain idle", 2'h0, {gain_load_a_pulse, gain_load_b_pulse})
      t_regs();
      t_refsel();
      t_pd();
      t_pipe();
      t_sync(4'h0);
      t_sync(4'h6);
      t_mr();
      stop_test();
   end
endmodule : tb
`default_nettype wire
